// ### rtl/prom_ctrl_regs.vh
// constants for the fuse prom host controller
`ifndef PROM_CTRL_REGS_VH
`define PROM_CTRL_REGS_VH
`define ADDR_W            10
`define DATA_W            8
`define WORDS             1024
`define CLK_PERIOD_PS     25000
`define PULSE_WIDTH_NS    7500
`define PULSE_CYC         ((`PULSE_WIDTH_NS * 1000) / `CLK_PERIOD_PS)
// sense delay plus this window must stay under 30 percent of a pulse period
`define PULSE_GAP_NS      2000
`define GAP_CYC           ((`PULSE_GAP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SENSE_DLY_NS      700
`define SENSE_DLY_CYC     ((`SENSE_DLY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SENSE_OFF_NS      10000
`define SENSE_OFF_CYC     ((`SENSE_OFF_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_ACC_NS       100
`define READ_ACC_CYC      ((`READ_ACC_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define EXTRA_PULSES      4
`define MAX_PULSES        100
`define CNT_W             10
`define PCNT_W            7
`endif

// ### rtl/prom_delay_timer.v
// reloadable down counter that pulses done once when it expires
`timescale 1ns/1ps
`default_nettype none
module prom_delay_timer #(
  parameter W = 10
) (
  input  wire         clock_i,
  input  wire         rst_n_i,
  input  wire         load_i,
  input  wire [W-1:0] count_i,
  output reg          done_o
);
  reg [W-1:0] cnt_q;
  reg         run_q;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= {W{1'b0}};
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_q <= count_i;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // prom_delay_timer
`default_nettype wire

// ### rtl/prom_host_ctrl.v
// host controller that reads and programs a 1024x8 fuse prom through its pins
`timescale 1ns/1ps
`default_nettype none
`include "prom_ctrl_regs.vh"

// Functional notes
// - ten address lines select the word to read or program
// - the same address lines serve reads and programming
// - deselect the device before any programming pulse
// - pulse train goes to the chosen bit's output with word addressed
// - after the bit senses one, give exactly four more pulses, then stop
// - wait at least 0.7 us after each pulse before sensing
// - sense current off 10 us before and after address changes
// - pulse lasts 7.5 us; duty cycle at least 70 percent
// - at most 100 pulses per bit; unverified bit is failed
module prom_host_ctrl (
  // clock and reset
  input  wire                 clock_i,
  input  wire                 resetn_i,
  // user command port
  input  wire                 read_req_i,
  input  wire                 prog_req_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [2:0]           bit_sel_i,
  output reg                  busy_o,
  output reg                  done_o,
  output reg                  fail_o,
  output reg  [`DATA_W-1:0]   rdata_o,
  // prom pins
  output reg  [`ADDR_W-1:0]   prom_addr_o,
  output reg                  select_low_a_n_o,
  output reg                  select_low_b_n_o,
  output reg                  select_high_a_o,
  output reg                  select_high_b_o,
  input  wire [`DATA_W-1:0]   prom_data_i,
  // programming driver controls, one pin at a time
  output reg  [`DATA_W-1:0]   pulse_en_o,
  output reg  [`DATA_W-1:0]   sense_en_o
);
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_READ  = 8'h02;
  localparam [7:0] S_PRE   = 8'h04;
  localparam [7:0] S_PULSE = 8'h08;
  localparam [7:0] S_SDLY  = 8'h10;
  localparam [7:0] S_GAP   = 8'h20;
  localparam [7:0] S_POST  = 8'h40;
  localparam [7:0] S_EXTRA = 8'h80;

  localparam integer       P_PULSE = `PULSE_CYC;
  localparam integer       P_GAP   = `GAP_CYC;
  localparam integer       P_SDLY  = `SENSE_DLY_CYC;
  localparam integer       P_OFF   = `SENSE_OFF_CYC;
  localparam integer       P_READ  = `READ_ACC_CYC;
  localparam integer       P_MAX   = `MAX_PULSES;
  localparam integer       P_EXTRA = `EXTRA_PULSES;
  // counts are cut to their counter widths on purpose; every value fits
  localparam [`CNT_W-1:0]  C_PULSE = P_PULSE[`CNT_W-1:0];
  localparam [`CNT_W-1:0]  C_GAP   = P_GAP[`CNT_W-1:0];
  localparam [`CNT_W-1:0]  C_SDLY  = P_SDLY[`CNT_W-1:0];
  localparam [`CNT_W-1:0]  C_OFF   = P_OFF[`CNT_W-1:0];
  localparam [`CNT_W-1:0]  C_READ  = P_READ[`CNT_W-1:0];
  localparam [`PCNT_W-1:0] C_MAX   = P_MAX[`PCNT_W-1:0];
  localparam [2:0]         C_EXTRA = P_EXTRA[2:0];

  reg                rst_s1_q;
  reg                rst_n_q;
  reg  [7:0]         state_q;
  reg  [`PCNT_W-1:0] pcnt_q;
  reg  [2:0]         xcnt_q;
  reg  [2:0]         bit_q;
  reg  [`DATA_W-1:0] onehot_q;
  reg                tload_q;
  reg  [`CNT_W-1:0]  tval_q;
  reg                verified_q;
  wire               tdone;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  prom_delay_timer #(.W(`CNT_W)) u_timer (
    .clock_i (clock_i),
    .rst_n_i (rst_n_q),
    .load_i  (tload_q),
    .count_i (tval_q),
    .done_o  (tdone)
  );

  always @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q          <= S_IDLE;
      pcnt_q           <= {`PCNT_W{1'b0}};
      xcnt_q           <= 3'h0;
      bit_q            <= 3'h0;
      onehot_q         <= 8'h00;
      tload_q          <= 1'b0;
      tval_q           <= {`CNT_W{1'b0}};
      verified_q       <= 1'b0;
      busy_o           <= 1'b0;
      done_o           <= 1'b0;
      fail_o           <= 1'b0;
      rdata_o          <= 8'h00;
      prom_addr_o      <= {`ADDR_W{1'b0}};
      select_low_a_n_o <= 1'b1;
      select_low_b_n_o <= 1'b1;
      select_high_a_o  <= 1'b0;
      select_high_b_o  <= 1'b0;
      pulse_en_o       <= 8'h00;
      sense_en_o       <= 8'h00;
    end else begin
      tload_q <= 1'b0;
      done_o  <= 1'b0;
      case (state_q)
        S_IDLE: begin
          busy_o <= 1'b0;
          if (read_req_i) begin
            // address and enables held until sampling
            prom_addr_o      <= addr_i;
            select_low_a_n_o <= 1'b0;
            select_low_b_n_o <= 1'b0;
            select_high_a_o  <= 1'b1;
            select_high_b_o  <= 1'b1;
            tval_q           <= C_READ;
            tload_q          <= 1'b1;
            busy_o           <= 1'b1;
            state_q          <= S_READ;
          end else if (prog_req_i) begin
            // deselected throughout programming
            prom_addr_o      <= addr_i;
            select_low_a_n_o <= 1'b1;
            select_high_a_o  <= 1'b0;
            bit_q            <= bit_sel_i;
            onehot_q         <= 8'h01 << bit_sel_i;
            pcnt_q           <= {`PCNT_W{1'b0}};
            xcnt_q           <= 3'h0;
            verified_q       <= 1'b0;
            fail_o           <= 1'b0;
            sense_en_o       <= 8'h00;
            tval_q           <= C_OFF;
            tload_q          <= 1'b1;
            busy_o           <= 1'b1;
            state_q          <= S_PRE;
          end
        end
        S_READ: begin
          if (tdone) begin
            rdata_o          <= prom_data_i;
            select_low_a_n_o <= 1'b1;
            select_low_b_n_o <= 1'b1;
            select_high_a_o  <= 1'b0;
            select_high_b_o  <= 1'b0;
            done_o           <= 1'b1;
            busy_o           <= 1'b0;
            state_q          <= S_IDLE;
          end
        end
        S_PRE: begin
          if (tdone) begin
            pulse_en_o <= onehot_q;
            pcnt_q     <= pcnt_q + 7'h01;
            tval_q     <= C_PULSE;
            tload_q    <= 1'b1;
            state_q    <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (tdone) begin
            pulse_en_o <= 8'h00;
            tval_q     <= verified_q ? C_GAP : C_SDLY;
            tload_q    <= 1'b1;
            state_q    <= verified_q ? S_EXTRA : S_SDLY;
          end
        end
        S_SDLY: begin
          // sense only after the trailing-edge delay
          if (tdone) begin
            sense_en_o <= onehot_q;
            tval_q     <= C_GAP;
            tload_q    <= 1'b1;
            state_q    <= S_GAP;
          end
        end
        S_GAP: begin
          // the gap keeps the pulse duty cycle legal
          if (tdone) begin
            sense_en_o <= 8'h00;
            if (prom_data_i[bit_q]) begin
              verified_q <= 1'b1;
              pulse_en_o <= onehot_q;
              xcnt_q     <= 3'h1;
              tval_q     <= C_PULSE;
              tload_q    <= 1'b1;
              state_q    <= S_PULSE;
            end else if (pcnt_q >= C_MAX) begin
              fail_o     <= 1'b1;
              tval_q     <= C_OFF;
              tload_q    <= 1'b1;
              state_q    <= S_POST;
            end else begin
              pulse_en_o <= onehot_q;
              pcnt_q     <= pcnt_q + 7'h01;
              tval_q     <= C_PULSE;
              tload_q    <= 1'b1;
              state_q    <= S_PULSE;
            end
          end
        end
        S_EXTRA: begin
          if (tdone) begin
            if (xcnt_q >= C_EXTRA) begin
              tval_q  <= C_OFF;
              tload_q <= 1'b1;
              state_q <= S_POST;
            end else begin
              pulse_en_o <= onehot_q;
              xcnt_q     <= xcnt_q + 3'h1;
              tval_q     <= C_PULSE;
              tload_q    <= 1'b1;
              state_q    <= S_PULSE;
            end
          end
        end
        S_POST: begin
          if (tdone) begin
            done_o  <= 1'b1;
            busy_o  <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // prom_host_ctrl
`default_nettype wire

// ### bench/prom_host_ctrl_checker.sv
// concurrent checks on the prom host controller pins
`timescale 1ns/1ps
`default_nettype none
module prom_host_ctrl_checker (
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       read_req_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic [9:0] prom_addr_o,
  input wire logic       select_low_a_n_o,
  input wire logic       select_high_a_o,
  input wire logic [7:0] pulse_en_o,
  input wire logic [7:0] sense_en_o
);
  logic [9:0] plen_q;
  logic [9:0] gap_q;
  logic [9:0] age_q;
  logic [9:0] soff_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ages saturate so a long idle span never wraps into a false hit
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      plen_q <= '0;
      gap_q  <= '1;
      age_q  <= '1;
      soff_q <= '1;
    end else begin
      plen_q <= (|pulse_en_o) ? plen_q + 10'h001 : 10'h000;
      gap_q  <= (|pulse_en_o) ? 10'h000 : gap_q + {9'h000, ~&gap_q};
      age_q  <= $changed(prom_addr_o) ? 10'h000 : age_q + {9'h000, ~&age_q};
      soff_q <= (|sense_en_o) ? 10'h000 : soff_q + {9'h000, ~&soff_q};
    end
  end
  sequence read_go;
    !busy_o && read_req_i;
  endsequence
  AST_PULSE_DESEL: assert property (|pulse_en_o |-> select_low_a_n_o && !select_high_a_o)
    else $error("pulse while selected");
  AST_ONE_BIT: assert property ($onehot0(pulse_en_o) && $onehot0(sense_en_o))
    else $error("several bits driven");
  AST_PULSE_WIDTH: assert property ($fell(|pulse_en_o) |-> plen_q inside {[285:315]})
    else $error("pulse width off");
  AST_SENSE_DELAY: assert property ($rose(|sense_en_o) |-> gap_q >= 10'd28)
    else $error("sense too soon");
  AST_SENSE_ADDR: assert property (|sense_en_o |-> age_q >= 10'd399)
    else $error("sense near address change");
  AST_ADDR_GAP: assert property ($changed(prom_addr_o) |->
    $past(sense_en_o) == 8'h00 && soff_q >= 10'd400)
    else $error("address moved under sense");
  // within a train the off time must stay under 30 percent of the period
  AST_PULSE_DUTY: assert property ($rose(|pulse_en_o) |->
    gap_q <= 10'd129 || gap_q >= 10'd399)
    else $error("pulse duty too low");
  AST_ADDR_HELD: assert property (busy_o && $past(busy_o) |-> $stable(prom_addr_o))
    else $error("address moved in access");
  AST_READ_DONE: assert property (read_go |-> ##7 done_o)
    else $error("read done late");
endmodule // prom_host_ctrl_checker
bind prom_host_ctrl prom_host_ctrl_checker prom_host_ctrl_checker_i (.clock_i, .resetn_i,
  .read_req_i, .busy_o, .done_o, .prom_addr_o, .select_low_a_n_o, .select_high_a_o,
  .pulse_en_o, .sense_en_o);
`default_nettype wire

// ### bench/prom_fuse_model.sv
// pin level model of the 1024x8 fuse prom
`timescale 1ns/1ps
`default_nettype none
module prom_fuse_model (
  input  wire logic [9:0] a_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [7:0] pulse_i,
  input  wire logic [7:0] sense_i,
  input  wire logic [7:0] blow_i,
  output wire logic [7:0] data_o
);
  logic [7:0] mem [1024];
  int         hits [8];
  wire        on = (sel_i == 4'h3);
  wire        pany = |pulse_i;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(a_i) foreach (hits[b]) hits[b] = 0;
  // a fuse blows only after blow_i pulses, and only while deselected
  always @(posedge pany)
    for (int b = 0; b < 8; b++)
      if (pulse_i[b] && !on) begin
        hits[b]++;
        if (hits[b] >= blow_i) mem[a_i][b] = 1'b1;
      end
  // released outputs sit at the pull-up, except the sensed pin
  assign data_o = on ? mem[a_i] : (mem[a_i] | ~sense_i);
endmodule // prom_fuse_model
`default_nettype wire

// ### bench/prom_host_ctrl_tb_top.sv
// self-checking bench for the prom host controller
`timescale 1ns/1ps
`default_nettype none
module prom_host_ctrl_tb_top;
  typedef struct {logic p; logic [9:0] a; logic [2:0] b; logic [7:0] bl, d; int n; logic f;}
    row_t;
  logic       clock_i = 1'b0, resetn_i = 1'b0, read_req_i = 1'b0, prog_req_i = 1'b0;
  logic [9:0] addr_i = 10'h000, prom_addr_o;
  logic [2:0] bit_sel_i = 3'h0;
  logic [7:0] blow = 8'h01, rdata_o, prom_data_i, pulse_en_o, sense_en_o;
  logic       busy_o, done_o, fail_o, select_low_a_n_o, select_low_b_n_o;
  logic       select_high_a_o, select_high_b_o;
  int         err_total = 0, compares = 0, npulse = 0, cyc = 0;
  wire        pany = |pulse_en_o;
  row_t rows [7] = '{'{0, 10'h000, 0, 1, 0, 0, 0}, '{0, 10'h3ff, 0, 1, 0, 0, 0},
    '{1, 10'h155, 5, 3, 0, 7, 0}, '{0, 10'h155, 0, 1, 8'h20, 0, 0},
    '{0, 10'h154, 0, 1, 0, 0, 0}, '{1, 10'h155, 0, 1, 0, 5, 0},
    '{0, 10'h155, 0, 1, 8'h21, 0, 0}};
  prom_host_ctrl prom_host_ctrl_i (.clock_i, .resetn_i, .read_req_i, .prog_req_i, .addr_i,
    .bit_sel_i, .busy_o, .done_o, .fail_o, .rdata_o, .prom_addr_o, .select_low_a_n_o,
    .select_low_b_n_o, .select_high_a_o, .select_high_b_o, .prom_data_i, .pulse_en_o,
    .sense_en_o);
  prom_fuse_model prom_fuse_model_i (.a_i(prom_addr_o), .pulse_i(pulse_en_o),
    .sel_i({select_low_a_n_o, select_low_b_n_o, select_high_a_o, select_high_b_o}),
    .sense_i(sense_en_o), .blow_i(blow), .data_o(prom_data_i));
  task automatic give_verdict;
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic op(input row_t r);
    blow <= r.bl;
    addr_i <= r.a;
    bit_sel_i <= r.b;
    read_req_i <= !r.p;
    prog_req_i <= r.p;
    npulse = 0;
    @(posedge clock_i);
    read_req_i <= 1'b0;
    prog_req_i <= 1'b0;
    do @(posedge clock_i); while (done_o !== 1'b1);
    if (!r.p) chk("rdata", {24'h0, r.d}, {24'h0, rdata_o});
    chk("fail", {31'h0, r.f}, {31'h0, fail_o});
    chk("pulses", r.n, npulse);
  endtask
  initial forever #12.5 clock_i = ~clock_i;
  always @(posedge pany) npulse++;
  // ceiling sized for one full 100 pulse failure plus the table
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    chk("reset pins", 32'h000c0000, {busy_o, done_o, fail_o, select_low_a_n_o,
      select_low_b_n_o, select_high_a_o, select_high_b_o, pulse_en_o, sense_en_o});
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    foreach (rows[i]) op(rows[i]);
    op(row_t'{1, 10'h3ff, 7, 8'hc8, 0, 100, 1});
    op(row_t'{0, 10'h3ff, 0, 1, 0, 0, 1});
    // reset in mid pulse must abort and deselect; fail is already low, the request cleared it
    blow <= 8'h02;
    addr_i <= 10'h200;
    bit_sel_i <= 3'h1;
    prog_req_i <= 1'b1;
    @(posedge clock_i);
    prog_req_i <= 1'b0;
    repeat (500) @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("mid reset pins", 32'h000c0000, {busy_o, done_o, fail_o, select_low_a_n_o,
      select_low_b_n_o, select_high_a_o, select_high_b_o, pulse_en_o, sense_en_o});
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    op(row_t'{0, 10'h200, 0, 1, 0, 0, 0});
    give_verdict();
  end
endmodule // prom_host_ctrl_tb_top
`default_nettype wire
